// ===== rtl/scwl_top.sv
// Chosen here: the placing of the registers and register access over Avalon-MM.
`include "scwl_map.svh"
`default_nettype none
module scwl_top (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [7:0]  parallel_data_bus_in,
  input  wire logic        word_load_clock_in,
  input  wire logic        frequency_update_strobe_in,
  input  wire logic        master_reset_in,
  input  wire logic        reference_clock_in,
  output logic      [31:0] tuning_word_out,
  output logic      [4:0]  phase_offset_bits_out,
  output logic             power_down_out,
  output logic             ref_multiplier_enable_out,
  output logic      [31:0] synth_phase_out,
  output logic             synth_tick_out
);

  scwl_pkg::scwl_state_t st;
  scwl_pkg::scwl_state_t next_st;

  logic [11:0] pins_sync;
  logic [7:0]  sy_data;
  logic        sy_wclk;
  logic        sy_strobe;
  logic        sy_mreset;
  logic        sy_ref;

  scwl_sync #(
    .W (12)
  ) u_sync (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({reference_clock_in, master_reset_in,
                  frequency_update_strobe_in, word_load_clock_in,
                  parallel_data_bus_in}),
    .sync_out   (pins_sync)
  );

  assign sy_data   = pins_sync[7:0];
  assign sy_wclk   = pins_sync[8];
  assign sy_strobe = pins_sync[9];
  assign sy_mreset = pins_sync[10];
  assign sy_ref    = pins_sync[11];

  logic        wclk_rise;
  logic        ref_rise;
  logic        in_full;
  logic        cap_go;
  logic        upd_go;
  logic        mr_go;
  logic        run_go;
  logic        mode_wr;
  logic [5:0]  pidx;
  logic [31:0] step;
  logic [31:0] rd_mux;

  // edges are found against the previous synchronised sample
  assign wclk_rise = sy_wclk & ~st.prev_wclk;
  assign ref_rise  = sy_ref & ~st.prev_ref;
  assign in_full   = st.serial_mode ? (st.in_count == `SCWL_SER_BITS)
                                    : (st.in_count == `SCWL_PAR_BYTES);
  assign cap_go    = wclk_rise & ~in_full;
  assign mr_go     = ref_rise & sy_mreset;
  assign upd_go    = ref_rise & ~sy_mreset & sy_strobe
                     & ~st.prev_strobe;
  assign run_go    = ref_rise & ~sy_mreset & ~upd_go & ~st.pd;
  assign mode_wr   = (st.bus_st == scwl_pkg::SCWL_BUS_ACK) & avs_write_in
                     & (avs_address_in == `SCWL_OFS_CTRL)
                     & avs_byteenable_in[0];
  assign pidx      = st.in_count - `SCWL_SER_PHASE;
  // one accumulator step of six times the tuning word per reference edge when multiplied
  assign step      = st.mult ? st.tune * `SCWL_MULT_FACTOR
                             : st.tune;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_in)
      `SCWL_OFS_CTRL: begin
        rd_mux[`SCWL_CTRL_SERIAL] = st.serial_mode;
      end
      `SCWL_OFS_STATUS: begin
        rd_mux[5:0] = st.in_count;
        rd_mux[8]   = in_full;
        rd_mux[9]   = st.overrun;
      end
      `SCWL_OFS_TUNE: begin
        rd_mux = st.tune;
      end
      `SCWL_OFS_CFG: begin
        rd_mux[`SCWL_B0_PHASE_HI:`SCWL_B0_PHASE_LO] = st.phase;
        rd_mux[`SCWL_B0_PD]   = st.pd;
        rd_mux[`SCWL_B0_FACT] = st.fact;
        rd_mux[`SCWL_B0_MULT] = st.mult;
      end
      `SCWL_OFS_ACC: begin
        rd_mux = st.out_phase;
      end
      `SCWL_OFS_IN_TUNE: begin
        rd_mux = st.in_tune;
      end
      `SCWL_OFS_IN_CFG: begin
        rd_mux[`SCWL_B0_PHASE_HI:`SCWL_B0_PHASE_LO] = st.in_phase;
        rd_mux[`SCWL_B0_PD]   = st.in_pd;
        rd_mux[`SCWL_B0_FACT] = st.in_fact;
        rd_mux[`SCWL_B0_MULT] = st.in_mult;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    next_st           = st;
    next_st.tick      = 1'b0;
    next_st.prev_wclk = sy_wclk;
    next_st.prev_ref  = sy_ref;

    // bus slave: one wait cycle, then the answer
    unique case (st.bus_st)
      scwl_pkg::SCWL_BUS_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          next_st.bus_st = scwl_pkg::SCWL_BUS_ACK;
          if (avs_read_in) begin
            next_st.rdata = rd_mux;
          end
        end
      end
      scwl_pkg::SCWL_BUS_ACK: begin
        next_st.bus_st = scwl_pkg::SCWL_BUS_IDLE;
      end
    endcase

    // word clock capture into the input data register
    if (cap_go) begin
      next_st.in_count = st.in_count + 6'h01;
      if (st.serial_mode) begin
        // bit seven of the data port doubles as serial input
        if (st.in_count < `SCWL_SER_MULT) begin
          next_st.in_tune[st.in_count[4:0]] =
            sy_data[`SCWL_SER_DATA_BIT];
        end else if (st.in_count == `SCWL_SER_MULT) begin
          next_st.in_mult = sy_data[`SCWL_SER_DATA_BIT];
        end else if (st.in_count == `SCWL_SER_FACT) begin
          next_st.in_fact = sy_data[`SCWL_SER_DATA_BIT];
        end else if (st.in_count == `SCWL_SER_PD) begin
          next_st.in_pd = sy_data[`SCWL_SER_DATA_BIT];
        end else begin
          next_st.in_phase[pidx[2:0]] =
            sy_data[`SCWL_SER_DATA_BIT];
        end
      end else begin
        unique case (st.in_count[2:0])
          3'h0: begin
            next_st.in_phase =
              sy_data[`SCWL_B0_PHASE_HI:`SCWL_B0_PHASE_LO];
            next_st.in_pd   = sy_data[`SCWL_B0_PD];
            next_st.in_fact = sy_data[`SCWL_B0_FACT];
            next_st.in_mult = sy_data[`SCWL_B0_MULT];
          end
          3'h1: begin
            next_st.in_tune[31:24] = sy_data;
          end
          3'h2: begin
            next_st.in_tune[23:16] = sy_data;
          end
          3'h3: begin
            next_st.in_tune[15:8] = sy_data;
          end
          3'h4: begin
            next_st.in_tune[7:0] = sy_data;
          end
          default: begin
            next_st.in_count = st.in_count;
          end
        endcase
      end
    end

    // a format change starts a fresh word
    if (mode_wr) begin
      next_st.serial_mode = avs_writedata_in[`SCWL_CTRL_SERIAL];
      next_st.in_tune     = 32'h0000_0000;
      next_st.in_phase    = 5'h00;
      next_st.in_pd       = 1'b0;
      next_st.in_fact     = 1'b0;
      next_st.in_mult     = 1'b0;
      next_st.in_count    = 6'h00;
      next_st.overrun     = 1'b0;
    end

    // reference clock side: strobe, master reset, accumulator
    if (ref_rise) begin
      next_st.prev_strobe = sy_strobe;
      next_st.tick        = 1'b1;
    end
    if (mr_go) begin
      next_st.in_tune  = 32'h0000_0000;
      next_st.in_phase = 5'h00;
      next_st.in_pd    = 1'b0;
      next_st.in_fact  = 1'b0;
      next_st.in_mult  = 1'b0;
      next_st.in_count = 6'h00;
      next_st.overrun  = 1'b0;
      next_st.tune     = 32'h0000_0000;
      next_st.phase    = 5'h00;
      next_st.pd       = 1'b0;
      next_st.fact     = 1'b0;
      next_st.mult     = 1'b0;
      next_st.acc      = 32'h0000_0000;
    end else if (upd_go) begin
      next_st.tune     = st.in_tune;
      next_st.phase    = st.in_phase;
      next_st.pd       = st.in_pd;
      next_st.fact     = st.in_fact;
      next_st.mult     = st.in_mult;
      next_st.in_tune  = 32'h0000_0000;
      next_st.in_phase = 5'h00;
      next_st.in_pd    = 1'b0;
      next_st.in_fact  = 1'b0;
      next_st.in_mult  = 1'b0;
      next_st.in_count = 6'h00;
      next_st.overrun  = 1'b0;
    end else if (run_go) begin
      next_st.acc = st.acc + step;
    end

    // extra clocks beyond a full word are dropped and flagged
    // the flag is set last so that a coinciding clear loses
    if (wclk_rise && !cap_go) begin
      next_st.overrun = 1'b1;
    end

    // phase offset weights: msb is half a cycle
    next_st.out_phase = next_st.acc
      + {next_st.phase, 27'h0000000};
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      st             <= '0;
      st.bus_st      <= scwl_pkg::SCWL_BUS_IDLE;
      st.serial_mode <= `SCWL_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in)
                               & (st.bus_st == scwl_pkg::SCWL_BUS_IDLE);
  assign avs_readdata_out          = st.rdata;
  assign tuning_word_out           = st.tune;
  assign phase_offset_bits_out     = st.phase;
  assign power_down_out            = st.pd;
  assign ref_multiplier_enable_out = st.mult;
  assign synth_phase_out           = st.out_phase;
  assign synth_tick_out            = st.tick;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);

  par_byte0_a: assert property (
    cap_go && !st.serial_mode && st.in_count == 6'h00
      && !upd_go && !mr_go && !mode_wr
    |=> st.in_phase == $past(sy_data[7:3])
      && st.in_pd == $past(sy_data[2])
      && st.in_mult == $past(sy_data[0]))
    else $error("first byte fields misplaced");

  par_tune_a: assert property (
    cap_go && !st.serial_mode && st.in_count == 6'h01
      && !upd_go && !mr_go && !mode_wr
    |=> st.in_tune[31:24] == $past(sy_data))
    else $error("second byte not in tuning msb");

  ser_first_a: assert property (
    cap_go && st.serial_mode && st.in_count == 6'h00
      && !upd_go && !mr_go && !mode_wr
    |=> st.in_tune[0] == $past(sy_data[7]))
    else $error("serial first bit not tuning lsb");

  count_step_a: assert property (
    cap_go && !upd_go && !mr_go && !mode_wr
    |=> st.in_count == $past(st.in_count) + 6'h01)
    else $error("load counter did not advance");

  word_hold_a: assert property (
    !wclk_rise && !ref_rise && !mode_wr
    |=> $stable(st.in_tune) && $stable(st.in_count))
    else $error("input register changed without word clock");

  update_apply_a: assert property (
    upd_go
    |=> st.tune == $past(st.in_tune) && st.in_tune == 32'h0
      && st.in_count == 6'h00)
    else $error("update did not apply and clear");

  mreset_clear_a: assert property (
    mr_go
    |=> st.tune == 32'h0 && st.acc == 32'h0 && st.in_count == 6'h00
      && synth_phase_out == 32'h0)
    else $error("master reset did not clear");

  ref_only_a: assert property (
    !ref_rise |=> $stable(st.tune) && $stable(st.acc))
    else $error("synthesis moved off a reference edge");

  mult_step_a: assert property (
    run_go && st.mult
    |=> st.acc == $past(st.acc) + $past(st.tune) * 32'h0000_0006)
    else $error("multiplied step wrong");

  pd_hold_a: assert property (
    ref_rise && st.pd && !upd_go && !mr_go |=> $stable(st.acc))
    else $error("accumulator ran in power-down");

  bus_wait_a: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out)
    else $error("bus answer not after one wait");

  overrun_flag_a: assert property (
    wclk_rise && !cap_go |=> st.overrun)
    else $error("dropped word clock not flagged");

  par_word_c: cover property (
    cap_go && !st.serial_mode && st.in_count == 6'h04);
  ser_word_c: cover property (
    cap_go && st.serial_mode && st.in_count == 6'h27);
  update_c: cover property (upd_go && st.in_count != 6'h00);
  mreset_c: cover property (mr_go ##[1:40] run_go);

endmodule
`default_nettype wire

// ===== inc/scwl_map.svh
// Behaviour
// - parallel word is five bytes on word clock
// - byte one control, bytes two-five tuning MSB first
// - serial word is forty bits, one per clock
// - data bit seven is MSB and serial input
// - input register captures only on word clock
// - update strobe applies input register, then clears it
// - master reset clears all, phase returns to zero
// - synthesis runs on reference clock rising edges
// - byte one: phase, power-down, zero, multiplier
// - serial order: tuning LSB first, then flags, phase
// - every control flag is active high
// - phase offset steps: half cycle down to 1/32
// - multiplier on gives six times reference rate
// - update strobe sampled on reference clock edge
// - master reset sampled on reference clock edge
`ifndef SCWL_MAP_SVH
`define SCWL_MAP_SVH

`define SCWL_OFS_CTRL       5'h00
`define SCWL_OFS_STATUS     5'h04
`define SCWL_OFS_TUNE       5'h08
`define SCWL_OFS_CFG        5'h0c
`define SCWL_OFS_ACC        5'h10
`define SCWL_OFS_IN_TUNE    5'h14
`define SCWL_OFS_IN_CFG     5'h18

`define SCWL_CTRL_SERIAL    0
`define SCWL_CTRL_RST       1'h0

`define SCWL_PAR_BYTES      6'h05
`define SCWL_SER_BITS       6'h28
`define SCWL_SER_MULT       6'h20
`define SCWL_SER_FACT       6'h21
`define SCWL_SER_PD         6'h22
`define SCWL_SER_PHASE      6'h23

`define SCWL_B0_PHASE_HI    7
`define SCWL_B0_PHASE_LO    3
`define SCWL_B0_PD          2
`define SCWL_B0_FACT        1
`define SCWL_B0_MULT        0
`define SCWL_SER_DATA_BIT   7

`define SCWL_MULT_FACTOR    32'h0000_0006
`define SCWL_PHASE_POS      27

`endif

// ===== inc/scwl_pkg.sv
`default_nettype none
package scwl_pkg;

  typedef enum logic {
    SCWL_BUS_IDLE,
    SCWL_BUS_ACK
  } scwl_bus_t;

  typedef struct packed {
    scwl_bus_t   bus_st;
    logic [31:0] rdata;
    logic        serial_mode;
    logic        prev_wclk;
    logic        prev_ref;
    logic        prev_strobe;
    logic [31:0] in_tune;
    logic [4:0]  in_phase;
    logic        in_pd;
    logic        in_fact;
    logic        in_mult;
    logic [5:0]  in_count;
    logic        overrun;
    logic [31:0] tune;
    logic [4:0]  phase;
    logic        pd;
    logic        fact;
    logic        mult;
    logic [31:0] acc;
    logic [31:0] out_phase;
    logic        tick;
  } scwl_state_t;

endpackage
`default_nettype wire

// ===== rtl/scwl_sync.sv
`default_nettype none
// two flip-flop synchroniser for pins from outside the clock domain
module scwl_sync #(
  parameter int W = 12
) (
  input  wire logic         mclk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scwl_sync_t;

  scwl_sync_t st;
  scwl_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;

endmodule
`default_nettype wire

// ===== bench/scwl_host.sv
`default_nettype none
// controller that loads words over the pin interface
module scwl_host (
  output logic [7:0] data_out,
  output logic       wclk_out,
  output logic       strobe_out,
  output logic       mreset_out,
  output logic       reference_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    data_out = 8'h00;
    wclk_out = 1'b0;
    strobe_out = 1'b0;
    mreset_out = 1'b0;
    reference_clock_out = 1'b0;
  end

  // free-running reference, unrelated in phase to the system clock
  // with a 36 ns half period every fifth edge lands on a system clock edge
  always #36 reference_clock_out = ~reference_clock_out;

  // the word clock stands low between units
  // the data lines flip once the hold has run out
  // every change stays clear of the system clock edges
  task automatic send_byte(input logic [7:0] b);
    #2 data_out = b;
    #40 wclk_out = 1'b1;
    #80 wclk_out = 1'b0;
    #20 data_out = ~b;
    #18;
  endtask

  // w holds {cfg, tune}; serial order is w[0] first
  task automatic load(input logic ser, input logic [39:0] w);
    if (ser) begin
      for (int n = 0; n < 40; n++) send_byte({w[n], 7'h00});
    end else begin
      for (int i = 0; i < 5; i++) send_byte(w[39-8*i -: 8]);
    end
  endtask

  task automatic pulse(input logic rst);
    #2;
    if (rst) mreset_out = 1'b1;
    else strobe_out = 1'b1;
    #200 mreset_out = 1'b0;
    strobe_out = 1'b0;
    #198;
  endtask
endmodule
`default_nettype wire

// ===== bench/test_synth_control_word_loader.sv
`default_nettype none
module test_synth_control_word_loader;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_rq;
  logic [7:0]  pdata;
  logic        wclk;
  logic        strobe;
  logic        mreset;
  logic        ref_clock;
  logic [31:0] tune;
  logic [4:0]  phase;
  logic        pd;
  logic        mult;
  logic [31:0] synth;
  logic        tick;
  logic [31:0] exp_q[$];
  int          fail_count = 0;
  int          check_count = 0;

  always #5 mclk_in = ~mclk_in;

  scwl_top DUT (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
    .parallel_data_bus_in(pdata), .word_load_clock_in(wclk),
    .frequency_update_strobe_in(strobe), .master_reset_in(mreset),
    .reference_clock_in(ref_clock), .tuning_word_out(tune),
    .phase_offset_bits_out(phase), .power_down_out(pd),
    .ref_multiplier_enable_out(mult), .synth_phase_out(synth),
    .synth_tick_out(tick)
  );

  scwl_host host (
    .data_out(pdata), .wclk_out(wclk), .strobe_out(strobe),
    .mreset_out(mreset), .reference_clock_out(ref_clock)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic compare(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    address <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    @(posedge mclk_in);
    while (wait_rq !== 1'b0 && n < 50) begin
      n++;
      @(posedge mclk_in);
    end
    if (n == 50) fail_count++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic read_reg(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // read data is taken at the edge that ends the wait
  always @(posedge mclk_in) begin
    if (rd && wait_rq === 1'b0 && exp_q.size() > 0) begin
      compare("readdata", exp_q.pop_front(), rdata);
    end
  end

  task automatic wait_tick;
    int n;
    n = 0;
    do @(posedge mclk_in); while (tick !== 1'b1 && ++n < 40);
    if (n == 40) fail_count++;
  endtask

  task automatic step_chk(input logic [31:0] step);
    logic [31:0] first;
    repeat (30) @(posedge mclk_in);
    wait_tick();
    first = synth;
    wait_tick();
    compare("synth step", step, synth - first);
  endtask

  initial begin
    #100us;
    fail_count++;
    summarize();
  end

  initial begin
    logic [39:0] w;
    void'($urandom(80805));
    repeat (10) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    compare("tuning", 32'h0, tune);
    read_reg(5'h1c, 32'h0);
    read_reg(5'h00, 32'h0);
    for (int m = 0; m < 2; m++) begin
      w = {8'($urandom()), 32'($urandom())};
      w[33] = 1'b0;
      bus(1'b1, 5'h00, 32'(m));
      host.load(m[0], w);
      read_reg(5'h14, w[31:0]);
      read_reg(5'h18, {24'h0, w[39:32]});
      read_reg(5'h04, m ? 32'h128 : 32'h105);
      host.pulse(1'b0);
      compare("tuning", w[31:0], tune);
      compare("phase", {27'h0, w[39:35]}, {27'h0, phase});
      compare("pd", {31'h0, w[34]}, {31'h0, pd});
      compare("mult", {31'h0, w[32]}, {31'h0, mult});
      read_reg(5'h0c, {24'h0, w[39:32]});
      read_reg(5'h14, 32'h0);
      read_reg(5'h04, 32'h0);
      step_chk(w[34] ? 32'h0 : w[31:0] * (w[32] ? 32'h6 : 32'h1));
    end
    bus(1'b1, 5'h00, 32'h0);
    for (int i = 0; i < 6; i++) host.send_byte(8'(i + 1));
    read_reg(5'h04, 32'h305);
    read_reg(5'h14, 32'h0203_0405);
    bus(1'b1, 5'h00, 32'h0);
    read_reg(5'h14, 32'h0);
    read_reg(5'h04, 32'h0);
    host.pulse(1'b1);
    compare("tuning", 32'h0, tune);
    compare("synth", 32'h0, synth);
    for (int k = 0; k < 5; k++) begin
      host.load(1'b0, {8'(8'h08 << k), 32'h0});
      host.pulse(1'b0);
      compare("phase offset", 32'h0800_0000 << k, synth);
    end
    summarize();
  end
endmodule
`default_nettype wire
